// file: acs_sequencer.sv
// Purpose: successive-approximation conversion sequencer with apb registers
// Assumes: comparator result sampled per bit; rc clock is a free pin
// Notes:   time counted in half bit periods
//
// How it works
// - one conversion lasts nine and a half bit periods
// - clock select 00/01/10 gives 2/8/32 oscillator periods, 11 rc clock
// - rc bit period comes from the rc clock, not the oscillator
// - two bit periods gap after completion, hold capacitor disconnected
// - hold capacitor never discharged between conversions
// - analog pins must be inputs, else the driven level is converted
// - port reads return zero on analog-configured pins
// - clearing start aborts; result keeps last complete or written value
// - after abort wait two bit periods then acquire selected channel
// - completion loads result, clears start, sets complete flag
// - writing start while powered begins conversion; reads one while running
// - channel select picks one of four channels
// - port configuration picks analog/digital pins
//
// Local design decisions: the placing of the registers and register access over APB.
`include "acs_consts.svh"
`timescale 1ns/10ps
module acs_sequencer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rc_clk,
  input  wire logic        i_cmp,
  input  wire logic [3:0]  i_pin_level,
  output logic      [1:0]  o_sel_ch,
  output logic             o_hold_conn,
  output logic             o_irq
);
  acs_pkg::acs_state_reg_type s_r;
  acs_pkg::acs_state_reg_type s_nxt;

  // analog mask per port configuration
  function automatic logic [3:0] analog_pins(input logic [1:0] cfg);
    unique case (cfg)
      2'h0:    analog_pins = 4'hF;
      2'h1:    analog_pins = 4'h7;
      2'h2:    analog_pins = 4'h3;
      default: analog_pins = 4'h0;
    endcase
  endfunction : analog_pins

  logic       wr_en;
  logic       rd_en;
  logic [5:0] div_top;
  logic       rc_edge;
  logic       tick;
  logic       go_now;
  logic       on_now;
  logic [3:0] port_rd;
  logic [3:0] pins_s;
  logic [3:0] pins_m;
  logic [3:0] pins_t;
  logic [3:0] pins_r;

  always_comb begin
    wr_en = i_psel && i_penable && i_pwrite;
    rd_en = i_psel && i_penable && !i_pwrite;
    unique case (s_r.ctrl[`ACS_CTRL_CKS_LO +: 2])
      2'h0:    div_top = `ACS_DIV_OSC2;
      2'h1:    div_top = `ACS_DIV_OSC8;
      default: div_top = `ACS_DIV_OSC32;
    endcase
    rc_edge = s_r.rc_sync[1] ^ s_r.rc_sync[2];
    if (s_r.ctrl[`ACS_CTRL_CKS_LO +: 2] == 2'h3) begin
      tick = rc_edge;
    end else begin
      tick = (s_r.div_cnt == 6'h00);
    end
    go_now  = s_r.ctrl[`ACS_CTRL_GO];
    on_now  = s_r.ctrl[`ACS_CTRL_ON];
    port_rd = pins_r & ~analog_pins(s_r.pcfg);
  end

  // pin synchroniser: a change counts once second and third agree
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pins_s <= 4'h0;
      pins_m <= 4'h0;
      pins_t <= 4'h0;
      pins_r <= 4'h0;
    end else begin
      pins_s <= i_pin_level;
      pins_m <= pins_s;
      pins_t <= pins_m;
      pins_r <= (pins_t & ~(pins_m ^ pins_t)) | (pins_r & (pins_m ^ pins_t));
    end
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.rc_sync = {s_r.rc_sync[1:0], i_rc_clk};
    if (tick || (s_r.div_cnt == 6'h00)) begin
      s_nxt.div_cnt = div_top - 6'h01;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt - 6'h01;
    end
    // apb access, one wait state
    if (i_psel && i_penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      if (rd_en) begin
        unique case (i_paddr)
          `ACS_OFS_CTRL:   s_nxt.prdata = {24'h00_0000, s_r.ctrl & 8'hDD};
          `ACS_OFS_CFG:    s_nxt.prdata = {30'h0000_0000, s_r.pcfg};
          `ACS_OFS_RESULT: s_nxt.prdata = {24'h00_0000, s_r.result};
          `ACS_OFS_STATUS: s_nxt.prdata = {31'h0000_0000, s_r.status};
          `ACS_OFS_MASK:   s_nxt.prdata = {31'h0000_0000, s_r.mask};
          `ACS_OFS_PORT:   s_nxt.prdata = {28'h000_0000, port_rd};
          `ACS_OFS_DIR:    s_nxt.prdata = {28'h000_0000, s_r.dir};
          default:         s_nxt.prdata = 32'h0000_0000;
        endcase
      end
      if (wr_en) begin
        unique case (i_paddr)
          `ACS_OFS_CTRL: begin
            // start only taken when already powered on
            s_nxt.ctrl = i_pwdata[7:0] & 8'hDD;
            if (!on_now) begin
              s_nxt.ctrl[`ACS_CTRL_GO] = 1'b0;
            end
          end
          `ACS_OFS_CFG:    s_nxt.pcfg   = i_pwdata[1:0];
          `ACS_OFS_RESULT: s_nxt.result = i_pwdata[7:0];
          `ACS_OFS_STATUS: s_nxt.status = s_r.status & ~i_pwdata[0:0];
          `ACS_OFS_MASK:   s_nxt.mask   = i_pwdata[0:0];
          `ACS_OFS_DIR:    s_nxt.dir    = i_pwdata[3:0];
          default: begin
          end
        endcase
      end
    end
    s_nxt.sel_ch = s_r.ctrl[`ACS_CTRL_CHS_LO +: 2];
    unique case (s_r.state)
      acs_pkg::ACS_IDLE: begin
        s_nxt.hold_conn = on_now;
        if (go_now && on_now) begin
          s_nxt.state     = acs_pkg::ACS_CONV;
          s_nxt.half_cnt  = `ACS_CONV_HALVES;
          s_nxt.hold_conn = 1'b0;
        end
      end
      acs_pkg::ACS_CONV: begin
        if (!s_nxt.ctrl[`ACS_CTRL_GO] || !s_nxt.ctrl[`ACS_CTRL_ON]) begin
          s_nxt.state    = acs_pkg::ACS_GAP;
          s_nxt.half_cnt = `ACS_GAP_HALVES;
        end else if (tick) begin
          if (s_r.half_cnt[0] == 1'b0 && s_r.half_cnt <= 5'h10) begin
            s_nxt.sar = {s_r.sar[6:0], i_cmp};
          end
          if (s_r.half_cnt == 5'h01) begin
            s_nxt.state    = acs_pkg::ACS_GAP;
            s_nxt.half_cnt = `ACS_GAP_HALVES;
            s_nxt.result   = s_r.sar;
            s_nxt.ctrl[`ACS_CTRL_GO] = 1'b0;
            s_nxt.status   = 1'b1;
          end else begin
            s_nxt.half_cnt = s_r.half_cnt - 5'h01;
          end
        end
      end
      default: begin
        s_nxt.hold_conn = 1'b0;
        if (tick) begin
          if (s_r.half_cnt == 5'h01) begin
            s_nxt.state = acs_pkg::ACS_IDLE;
          end else begin
            s_nxt.half_cnt = s_r.half_cnt - 5'h01;
          end
        end
      end
    endcase
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.dir <= `ACS_DIR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_prdata    = s_r.prdata;
    o_pready    = s_r.pready;
    o_pslverr   = 1'b0;
    o_sel_ch    = s_r.sel_ch;
    o_hold_conn = s_r.hold_conn;
    o_irq       = s_r.irq;
  end
endmodule : acs_sequencer

// file: acs_consts.svh
// Purpose: constants of the conversion sequencer
// Assumes: 50 MHz system clock, APB with 32-bit data
// Notes:   offsets are byte addresses
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_OFS_CTRL      12'h000
`define ACS_OFS_CFG       12'h004
`define ACS_OFS_RESULT    12'h008
`define ACS_OFS_STATUS    12'h00C
`define ACS_OFS_MASK      12'h010
`define ACS_OFS_PORT      12'h014
`define ACS_OFS_DIR       12'h018
`define ACS_CTRL_ON       0
`define ACS_CTRL_GO       2
`define ACS_CTRL_CHS_LO   3
`define ACS_CTRL_CKS_LO   6
`define ACS_DIR_RESET     4'hF
`define ACS_DIV_OSC2      6'h01
`define ACS_DIV_OSC8      6'h04
`define ACS_DIV_OSC32     6'h10
`define ACS_CONV_HALVES   5'h13
`define ACS_GAP_HALVES    5'h04
`define ACS_RC_SYNC_W     3
`endif

// file: acs_pkg.sv
// Purpose: types of the conversion sequencer
// Assumes: nothing
// Notes:   constants live in acs_consts.svh
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_CONV,
    ACS_GAP
  } acs_state_type;

  typedef struct packed {
    acs_state_type state;
    logic [7:0]    ctrl;
    logic [1:0]    pcfg;
    logic [7:0]    result;
    logic [7:0]    sar;
    logic [0:0]    status;
    logic [0:0]    mask;
    logic [3:0]    dir;
    logic [5:0]    div_cnt;
    logic [4:0]    half_cnt;
    logic [2:0]    rc_sync;
    logic          hold_conn;
    logic          irq;
    logic [31:0]   prdata;
    logic          pready;
    logic [1:0]    sel_ch;
  } acs_state_reg_type;
endpackage : acs_pkg

// file: acs_sequencer_asserts.sv
// Purpose: port checks of acs_sequencer
// Assumes: one wait state apb
// Notes:   bound at foot
`include "acs_consts.svh"
`timescale 1ns/10ps
module acs_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [1:0]  o_sel_ch,
  input wire logic        o_hold_conn,
  input wire logic        o_irq
);
  logic [1:0] cfg_r;
  logic       mask_r;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r  <= 2'h0;
      mask_r <= 1'h0;
    end else if (o_pready && i_pwrite) begin
      if (i_paddr == `ACS_OFS_CFG) cfg_r <= i_pwdata[1:0];
      if (i_paddr == `ACS_OFS_MASK) mask_r <= i_pwdata[0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready long");
  a_no_error: assert property (!o_pslverr) else $error("pslverr set");
  a_unmapped_zero: assert property (o_pready && !i_pwrite && i_paddr == 12'h01C
    |-> o_prdata == 32'h0) else $error("unmapped read");
  a_port_analog: assert property (o_pready && !i_pwrite && i_paddr == `ACS_OFS_PORT
    && cfg_r == 2'h0 |-> o_prdata[3:0] == 4'h0) else $error("analog pin read");
  a_hold_gap: assert property ($fell(o_hold_conn) |-> !o_hold_conn [*3])
    else $error("hold gap short");
  a_sel_track: assert property (o_pready && i_pwrite && i_paddr == `ACS_OFS_CTRL
    |=> ##1 o_sel_ch == $past(i_pwdata[4:3], 2)) else $error("channel");
  a_irq_masked: assert property (!mask_r && !$past(mask_r) |-> !o_irq) else $error("irq");
  cover property (o_irq);
  cover property ($fell(o_hold_conn));
  cover property (o_pready && i_paddr == `ACS_OFS_RESULT);
endmodule : acs_chk
bind acs_sequencer acs_chk i_acs_chk (.*);

// file: acs_analog_model.sv
// Purpose: analog pins and rc oscillator
// Assumes: comparator level per channel
// Notes:   odd channels give FF
`timescale 1ns/10ps
module acs_analog_model (
  input  wire logic [1:0] i_sel_ch,
  output logic            o_cmp,
  output logic            o_rc_clk,
  output logic [3:0]      o_pin_level
);
  initial o_rc_clk = 1'h0;
  // each edge is half a 4 us bit period
  always #2000 o_rc_clk = ~o_rc_clk;
  assign o_cmp = i_sel_ch[0];
  assign o_pin_level = 4'hA;
endmodule : acs_analog_model

// file: acs_sequencer_test.sv
// Purpose: register tests of acs_sequencer
// Assumes: one wait state apb
// Notes:   odd channels give FF
`include "acs_consts.svh"
`timescale 1ns/10ps
module acs_sequencer_test;
  logic        i_sys_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic        i_psel = 1'h0;
  logic        i_penable = 1'h0;
  logic        i_pwrite = 1'h0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic [31:0] rd;
  logic        o_pready, o_pslverr, i_rc_clk, i_cmp, o_hold_conn, o_irq;
  logic [3:0]  i_pin_level;
  logic [1:0]  o_sel_ch;
  int          num_errors = 0;
  int          compares = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  acs_sequencer i_acs_sequencer (.*);
  acs_analog_model i_acs_analog_model (.i_sel_ch(o_sel_ch), .o_cmp(i_cmp),
    .o_rc_clk(i_rc_clk), .o_pin_level(i_pin_level));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'h1;
    do @(posedge i_sys_clk); while (o_pready !== 1'h1);
    rd = o_prdata;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_sys_clk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic conv(input logic [1:0] ch, input logic [1:0] ck, input logic m);
    apb(1'h1, `ACS_OFS_MASK, {31'h0, m});
    apb(1'h1, `ACS_OFS_CTRL, {24'h0, ck, 1'h0, ch, 3'h1});
    repeat (20) @(posedge i_sys_clk);
    apb(1'h1, `ACS_OFS_CTRL, {24'h0, ck, 1'h0, ch, 3'h5});
    apb(1'h0, `ACS_OFS_CTRL, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    do apb(1'h0, `ACS_OFS_CTRL, 32'h0); while (rd[2] !== 1'h0);
    chk({31'h0, o_irq}, {31'h0, m});
    apb(1'h0, `ACS_OFS_RESULT, 32'h0);
    chk(rd, {24'h0, {8{ch[0]}}});
    apb(1'h1, `ACS_OFS_STATUS, 32'h1);
    apb(1'h0, `ACS_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : conv
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    @(posedge i_sys_clk);
    apb(1'h0, `ACS_OFS_DIR, 32'h0);
    chk(rd, {28'h0, `ACS_DIR_RESET});
    apb(1'h0, 12'h01C, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, `ACS_OFS_PORT, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, `ACS_OFS_CFG, 32'h3);
    apb(1'h0, `ACS_OFS_PORT, 32'h0);
    chk(rd, 32'hA);
    for (int i = 0; i < 4; i++) begin
      conv(i[1:0], i[1:0], i != 2);
    end
    apb(1'h1, `ACS_OFS_RESULT, 32'h5A);
    apb(1'h1, `ACS_OFS_CTRL, 32'h85);
    apb(1'h1, `ACS_OFS_CTRL, 32'h81);
    repeat (100) @(posedge i_sys_clk);
    apb(1'h0, `ACS_OFS_RESULT, 32'h0);
    chk(rd, 32'h5A);
    apb(1'h0, `ACS_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, `ACS_OFS_CTRL, 32'h0);
    apb(1'h1, `ACS_OFS_CTRL, 32'h5);
    apb(1'h0, `ACS_OFS_CTRL, 32'h0);
    chk(rd & 32'h5, 32'h1);
    tally_and_finish();
  end
endmodule : acs_sequencer_test
